// file: logic/hsc_top.sv
/*
 Four-channel high-speed pulse counter with compare output and
 frequency meter, reached over a word-wide register port.
 Assumes scanEnd and progLoad are one-cycle pulses from core_clk logic,
 and pulse pins are asynchronous to core_clk.
*/
// Design decisions made here: the register offsets and strobed register access.
// Operation
// - Gate low idles; counting starts after scan end
// - Reset flag reinitialises value at scan end
// - Single-phase match sets output, restarts from zero
// - Preset one is high and low words
// - Two-phase match without keep starts new cycle
// - Compare output holds until clear flag raised
// - Two-phase reload value is word pair
// - Frequency mode counts pulses over window, stores
// - Result within one window plus one scan
// - Each channel has its own result register
// - Frequency mode disables ordinary counting
// - Measure only while gate high; cycle restarts
// - Load with gate high halts until cycled
// - Refresh returns latest value within 250 ms
// - Reset reloads two-phase, clears single-phase
// - Count up when A leads B, else down
// - New preset active after old preset reached
`timescale 1ns/100ps
`include "hsc_defs.svh"
module hsc_top #(
   parameter int WIN_CYC = `HSC_WIN_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Scan sequencing
   input wire logic scanEnd,
   input wire logic progLoad,
   // Pulse pins
   input wire logic phaseAIn,
   input wire logic phaseBIn,
   input wire logic pulseCh2In,
   input wire logic pulseCh3In,
   input wire logic pulseCh4In,
   // Register port
   input wire logic [`HSC_AW-1:0] regAddr,
   input wire logic [`HSC_DW-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [`HSC_DW-1:0] regRdData,
   // Outputs
   output logic [`HSC_NCH-1:0] compareOut,
   output logic irq
);
   localparam int NCH = `HSC_NCH;
   localparam int WW = $clog2(WIN_CYC);

   // Global registers
   logic [15:0] ctrl_ff;
   logic [15:0] mode_ff;
   logic [15:0] irqEn_ff;
   logic [15:0] irqStat_ff;
   logic [15:0] rdData_ff;

   // Per-channel views for status and readback
   logic [NCH-1:0] run;
   logic [NCH-1:0] halt;
   logic [NCH-1:0] match;
   logic [NCH-1:0] publish;
   logic [NCH-1:0] cmpOut;
   hsc_pkg::hsc_val_t presetV [NCH];
   hsc_pkg::hsc_val_t reloadV [NCH];
   hsc_pkg::hsc_val_t curV [NCH];
   hsc_pkg::hsc_val_t freqV [NCH];

   // Address decode
   logic chPage;
   logic [1:0] chSel;
   logic [2:0] field;
   logic [15:0] irqEvents;
   logic [15:0] irqClr;

   assign chPage = (regAddr[7:5] == `HSC_CH_PAGE);
   assign chSel = regAddr[4:3];
   assign field = regAddr[2:0];

   // Control flags written by the scan program
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_ff <= `HSC_CTRL_RST_VAL;
      end else if (regWr && regAddr == `HSC_REG_CTRL) begin
         ctrl_ff <= regWrData;
      end
   end

   // Frequency mode per channel
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         mode_ff <= `HSC_MODE_RST_VAL;
      end else if (regWr && regAddr == `HSC_REG_MODE) begin
         mode_ff <= regWrData;
      end
   end

   // Interrupt enable
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         irqEn_ff <= `HSC_IRQ_EN_RST_VAL;
      end else if (regWr && regAddr == `HSC_REG_IRQ_EN) begin
         irqEn_ff <= regWrData;
      end
   end

   // Sticky status; a new event beats a clear in the same cycle
   assign irqClr = (regWr && regAddr == `HSC_REG_IRQ_CLR) ? regWrData : 16'h0000;
   assign irqEvents = {8'h00, publish, match};

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         irqStat_ff <= 16'h0000;
      end else begin
         irqStat_ff <= (irqStat_ff & ~irqClr) | irqEvents;
      end
   end

   assign irq = |(irqStat_ff & irqEn_ff);

   // Channel logic
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : gCh
         hsc_cnt_if cntIf ();
         hsc_pkg::hsc_val_t preset_ff;
         hsc_pkg::hsc_val_t reload_ff;
         hsc_pkg::hsc_val_t active_ff;
         hsc_pkg::hsc_val_t cur_ff;
         hsc_pkg::hsc_val_t nxt_cur;
         hsc_pkg::hsc_val_t restartVal;
         hsc_pkg::hsc_val_t fcnt_ff;
         hsc_pkg::hsc_val_t pend_ff;
         hsc_pkg::hsc_val_t freq_ff;
         logic [WW-1:0] win_ff;
         logic run_ff;
         logic halt_ff;
         logic cmp_ff;
         logic pendValid_ff;
         logic gateFlag;
         logic rstFlag;
         logic clrFlag;
         logic freqMode;
         logic twoPh;
         logic keep;
         logic step;
         logic counting;
         logic measuring;
         logic winEnd;
         logic refresh;
         logic wrCh;
         logic pinA;
         logic pinB;

         // Channel one alone has a phase A pin
         if (g == 0) begin : gPinOne
            assign pinA = phaseAIn;
            assign pinB = phaseBIn;
         end else if (g == 1) begin : gPinTwo
            assign pinA = 1'b0;
            assign pinB = pulseCh2In;
         end else if (g == 2) begin : gPinThree
            assign pinA = 1'b0;
            assign pinB = pulseCh3In;
         end else begin : gPinFour
            assign pinA = 1'b0;
            assign pinB = pulseCh4In;
         end

         assign gateFlag = ctrl_ff[`HSC_CTRL_GATE + g];
         assign rstFlag = ctrl_ff[`HSC_CTRL_RST + g];
         assign clrFlag = ctrl_ff[`HSC_CTRL_CCLR + g];
         assign freqMode = mode_ff[g];
         assign twoPh = (g == 0) && ctrl_ff[`HSC_CTRL_TWOPH] && !freqMode;
         assign keep = ctrl_ff[`HSC_CTRL_KEEP];
         assign wrCh = regWr && chPage && (chSel == 2'(g));
         assign refresh = regWr && (regAddr == `HSC_REG_REFRESH) && regWrData[g];

         hsc_pin_sync uSync (
            .core_clk(core_clk),
            .resetn(resetn),
            .phaseAIn(pinA),
            .phaseBIn(pinB),
            .twoPhase(twoPh),
            .evt(cntIf.src)
         );

         assign step = cntIf.upPulse | cntIf.dnPulse;
         assign counting = run_ff && !freqMode;
         assign measuring = run_ff && freqMode;
         assign nxt_cur = cntIf.upPulse ? cur_ff + 32'h1 : cur_ff - 32'h1;
         assign restartVal = twoPh ? reload_ff : 32'h0;
         assign match[g] = counting && step && (nxt_cur == active_ff);

         // Preset and reload as high and low word pairs
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               preset_ff <= 32'h0;
               reload_ff <= 32'h0;
            end else if (wrCh) begin
               if (field == `HSC_F_PRE_HI) preset_ff[31:16] <= regWrData;
               if (field == `HSC_F_PRE_LO) preset_ff[15:0] <= regWrData;
               if (field == `HSC_F_RLD_HI) reload_ff[31:16] <= regWrData;
               if (field == `HSC_F_RLD_LO) reload_ff[15:0] <= regWrData;
            end
         end

         // Preset edits wait until the old preset is reached, a load, or a scan end with the reset flag
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               active_ff <= 32'h0;
            end else if (progLoad || (scanEnd && rstFlag)) begin
               active_ff <= preset_ff;
            end else if (match[g]) begin
               active_ff <= preset_ff;
            end
         end

         // Gate sampled only at scan end; a halted channel stays idle
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               run_ff <= 1'b0;
            end else if (progLoad) begin
               run_ff <= 1'b0;
            end else if (scanEnd) begin
               run_ff <= gateFlag && !halt_ff;
            end
         end

         // Load with gate high halts until the gate is seen low
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               halt_ff <= 1'b0;
            end else if (progLoad) begin
               halt_ff <= gateFlag;
            end else if (scanEnd && !gateFlag) begin
               halt_ff <= 1'b0;
            end
         end

         // Current value: load, reset flag, match restart, then counting
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               cur_ff <= 32'h0;
            end else if (progLoad) begin
               cur_ff <= restartVal;
            end else if (scanEnd && rstFlag) begin
               cur_ff <= restartVal;
            end else if (match[g] && !(twoPh && keep)) begin
               cur_ff <= restartVal;
            end else if (counting && step) begin
               cur_ff <= nxt_cur;
            end
         end

         // Compare output latches; a match wins over the clear flag
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               cmp_ff <= 1'b0;
            end else if (match[g]) begin
               cmp_ff <= 1'b1;
            end else if (clrFlag) begin
               cmp_ff <= 1'b0;
            end
         end

         // Window counter restarts whenever measuring drops
         assign winEnd = measuring && (win_ff == WW'(WIN_CYC - 1));

         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               win_ff <= '0;
               fcnt_ff <= 32'h0;
            end else if (!measuring) begin
               win_ff <= '0;
               fcnt_ff <= 32'h0;
            end else if (winEnd) begin
               win_ff <= '0;
               fcnt_ff <= {31'h0, step};
            end else begin
               win_ff <= win_ff + WW'(1);
               fcnt_ff <= fcnt_ff + {31'h0, step};
            end
         end

         // Pulses per window scaled to hertz, held until published
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               pend_ff <= 32'h0;
            end else if (winEnd) begin
               pend_ff <= 32'((fcnt_ff + {31'h0, step}) * `HSC_HZ_SCALE);
            end
         end

         // Pending flag; a window end beats the publish clear
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               pendValid_ff <= 1'b0;
            end else if (winEnd) begin
               pendValid_ff <= 1'b1;
            end else if (publish[g]) begin
               pendValid_ff <= 1'b0;
            end
         end

         // Publish at the next scan end, or at once on refresh
         assign publish[g] = (scanEnd && pendValid_ff) || refresh;

         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               freq_ff <= 32'h0;
            end else if (publish[g]) begin
               freq_ff <= pend_ff;
            end
         end

         assign run[g] = run_ff;
         assign halt[g] = halt_ff;
         assign cmpOut[g] = cmp_ff;
         assign presetV[g] = preset_ff;
         assign reloadV[g] = reload_ff;
         assign curV[g] = cur_ff;
         assign freqV[g] = freq_ff;
      end
   endgenerate

   assign compareOut = cmpOut;

   // Read data registered, valid the cycle after the strobe only
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rdData_ff <= 16'h0000;
      end else if (!regRd) begin
         rdData_ff <= 16'h0000;
      end else if (chPage) begin
         unique case (field)
            `HSC_F_PRE_HI: rdData_ff <= presetV[chSel][31:16];
            `HSC_F_PRE_LO: rdData_ff <= presetV[chSel][15:0];
            `HSC_F_RLD_HI: rdData_ff <= reloadV[chSel][31:16];
            `HSC_F_RLD_LO: rdData_ff <= reloadV[chSel][15:0];
            `HSC_F_CUR_HI: rdData_ff <= curV[chSel][31:16];
            `HSC_F_CUR_LO: rdData_ff <= curV[chSel][15:0];
            `HSC_F_FRQ_HI: rdData_ff <= freqV[chSel][31:16];
            `HSC_F_FRQ_LO: rdData_ff <= freqV[chSel][15:0];
         endcase
      end else begin
         case (regAddr)
            `HSC_REG_CTRL: rdData_ff <= ctrl_ff;
            `HSC_REG_MODE: rdData_ff <= mode_ff;
            `HSC_REG_STAT: rdData_ff <= {4'h0, halt, run, cmpOut};
            `HSC_REG_IRQ_STAT: rdData_ff <= irqStat_ff;
            `HSC_REG_IRQ_EN: rdData_ff <= irqEn_ff;
            default: rdData_ff <= 16'h0000;
         endcase
      end
   end

   assign regRdData = rdData_ff;
endmodule

// file: logic/hsc_defs.svh
/*
 Constants of the pulse counter and frequency meter: register offsets,
 field positions, reset values and timing counts.
 Assumes a 20 MHz core clock and a 16-bit word-wide register port.
*/
`ifndef HSC_DEFS_SVH
`define HSC_DEFS_SVH

// Sizes
`define HSC_NCH 4
`define HSC_AW 8
`define HSC_DW 16

// Global registers
`define HSC_REG_CTRL 8'h00
`define HSC_REG_MODE 8'h01
`define HSC_REG_STAT 8'h02
`define HSC_REG_IRQ_STAT 8'h03
`define HSC_REG_IRQ_CLR 8'h04
`define HSC_REG_IRQ_EN 8'h05
`define HSC_REG_REFRESH 8'h06

// Channel blocks: 0x20 + 8*channel, field in the low three bits
`define HSC_CH_PAGE 3'h1
`define HSC_F_PRE_HI 3'h0
`define HSC_F_PRE_LO 3'h1
`define HSC_F_RLD_HI 3'h2
`define HSC_F_RLD_LO 3'h3
`define HSC_F_CUR_HI 3'h4
`define HSC_F_CUR_LO 3'h5
`define HSC_F_FRQ_HI 3'h6
`define HSC_F_FRQ_LO 3'h7

// Control register fields
`define HSC_CTRL_GATE 0
`define HSC_CTRL_RST 4
`define HSC_CTRL_CCLR 8
`define HSC_CTRL_KEEP 12
`define HSC_CTRL_TWOPH 13

// Status register fields
`define HSC_STAT_CMP 0
`define HSC_STAT_RUN 4
`define HSC_STAT_HALT 8

// Interrupt fields: compare match, then new frequency result
`define HSC_IRQ_MATCH 0
`define HSC_IRQ_FREQ 4

// Reset values
`define HSC_CTRL_RST_VAL 16'h0000
`define HSC_MODE_RST_VAL 16'h0000
`define HSC_IRQ_EN_RST_VAL 16'h0000

// Timing
`define HSC_CLK_HZ 20000000
`define HSC_WIN_MS 250
`define HSC_WIN_CYC (`HSC_CLK_HZ / 1000 * `HSC_WIN_MS)
`define HSC_HZ_SCALE (1000 / `HSC_WIN_MS)

`endif

// file: logic/hsc_pkg.sv
/*
 Types shared by the pulse counter modules.
 Assumes hsc_defs.svh for all numeric constants.
*/
package hsc_pkg;
   typedef logic [31:0] hsc_val_t;
   typedef logic [15:0] hsc_half_t;
endpackage

// file: logic/hsc_cnt_if.sv
/*
 Count events passed from a pin decoder to the counter core.
 Assumes both ends run on core_clk.
*/
`timescale 1ns/100ps
interface hsc_cnt_if;
   logic upPulse;
   logic dnPulse;
   modport src (output upPulse, output dnPulse);
   modport snk (input upPulse, input dnPulse);
endinterface

// file: logic/hsc_pin_sync.sv
/*
 Pin synchroniser and edge decoder for one counter channel.
 Assumes asynchronous pins; emits one-cycle count pulses on core_clk.
*/
`timescale 1ns/100ps
module hsc_pin_sync (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Pins
   input wire logic phaseAIn,
   input wire logic phaseBIn,
   // Mode: quadrature when high, plain count otherwise
   input wire logic twoPhase,
   // Decoded events
   hsc_cnt_if.src evt
);
   logic [2:0] aSync_ff;
   logic [2:0] bSync_ff;
   logic aStable_ff;
   logic bStable_ff;
   logic nxt_aStable;
   logic nxt_bStable;
   logic bRise;

   // Three stages; stage one feeds only stage two
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         aSync_ff <= 3'h0;
         bSync_ff <= 3'h0;
      end else begin
         aSync_ff <= {aSync_ff[1:0], phaseAIn};
         bSync_ff <= {bSync_ff[1:0], phaseBIn};
      end
   end

   // A level is accepted only once stages two and three agree
   always_comb begin
      nxt_aStable = (aSync_ff[1] == aSync_ff[2]) ? aSync_ff[2] : aStable_ff;
      nxt_bStable = (bSync_ff[1] == bSync_ff[2]) ? bSync_ff[2] : bStable_ff;
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         aStable_ff <= 1'b0;
         bStable_ff <= 1'b0;
      end else begin
         aStable_ff <= nxt_aStable;
         bStable_ff <= nxt_bStable;
      end
   end

   // One pulse per accepted rising edge of B
   assign bRise = nxt_bStable & ~bStable_ff;

   // A high at the B edge means A leads: count up, else down
   assign evt.upPulse = bRise & (~twoPhase | aStable_ff);
   assign evt.dnPulse = bRise & twoPhase & ~aStable_ff;
endmodule

// file: tb/hsc_top_props.sv
/*
 Port checker for the pulse counter top.
 Assumes it is bound to hsc_top; shadows the words software writes.
*/
`timescale 1ns/100ps
`include "hsc_defs.svh"
module hsc_top_props #(
   parameter int WIN_CYC = `HSC_WIN_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Scan sequencing
   input wire logic scanEnd,
   input wire logic progLoad,
   // Register port
   input wire logic [`HSC_AW-1:0] regAddr,
   input wire logic [`HSC_DW-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [`HSC_DW-1:0] regRdData,
   // Outputs
   input wire logic [`HSC_NCH-1:0] compareOut,
   input wire logic irq
);
   logic [15:0] ctrlSh_ff;
   logic [15:0] enSh_ff;
   logic [3:0] runSh_ff;

   // Shadows of written words; status words cannot be seen from here
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ctrlSh_ff <= 16'h0000;
         enSh_ff <= 16'h0000;
      end else if (regWr && regAddr == `HSC_REG_CTRL) begin
         ctrlSh_ff <= regWrData;
      end else if (regWr && regAddr == `HSC_REG_IRQ_EN) begin
         enSh_ff <= regWrData;
      end
   end

   // Run estimate: over-approximate, since halt is hidden from the ports
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         runSh_ff <= 4'h0;
      end else if (progLoad) begin
         runSh_ff <= 4'h0;
      end else if (scanEnd) begin
         runSh_ff <= ctrlSh_ff[3:0];
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);

   rdata_idle_a: assert property (!$past(regRd) |-> regRdData == 16'h0000)
      else $error("read data not idle");
   ctrl_readback_a: assert property (regRd && regAddr == `HSC_REG_CTRL |=> regRdData == $past(ctrlSh_ff))
      else $error("control word readback wrong");
   irqen_readback_a: assert property (regRd && regAddr == `HSC_REG_IRQ_EN |=> regRdData == $past(enSh_ff))
      else $error("interrupt enable readback wrong");
   stat_mirror_a: assert property (regRd && regAddr == `HSC_REG_STAT |=> regRdData[3:0] == $past(compareOut))
      else $error("status does not mirror compare outputs");
   unmapped_zero_a: assert property (regRd && regAddr > 8'h06 && regAddr < 8'h20 |=> regRdData == 16'h0000)
      else $error("unmapped read not zero");
   irq_masked_a: assert property (enSh_ff == 16'h0000 |-> !irq)
      else $error("interrupt while all enables low");
   cmp_hold_a: assert property ((($past(compareOut) & ~compareOut) & ~($past(ctrlSh_ff[11:8]) | ctrlSh_ff[11:8])) == 4'h0)
      else $error("compare output dropped without clear flag");
   cmp_gated_a: assert property ((compareOut & ~$past(compareOut) & ~$past(runSh_ff)) == 4'h0)
      else $error("compare output rose on idle channel");
   rst_quiet_a: assert property ($rose(resetn) |-> compareOut == 4'h0 && !irq && regRdData == 16'h0000)
      else $error("outputs not quiet after reset");
endmodule

bind hsc_top hsc_top_props #(.WIN_CYC(WIN_CYC)) u_props (.core_clk(core_clk), .resetn(resetn),
   .scanEnd(scanEnd), .progLoad(progLoad), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
   .regRd(regRd), .regRdData(regRdData), .compareOut(compareOut), .irq(irq));

// file: tb/hsc_pulse_src.sv
/*
 Pulse source model: an encoder on channel one and sensors on the rest.
 Assumes the bench calls its tasks; pins move off the clock edge.
*/
`timescale 1ns/100ps
module hsc_pulse_src (
   // Clock
   input wire logic core_clk,
   // Pins
   output logic phaseAIn,
   output logic phaseBIn,
   output logic [3:1] pulseIn
);
   // Pins idle low between bursts
   initial {phaseAIn, phaseBIn, pulseIn} = 5'h00;

   // Offset keeps pin edges away from the sampling edge
   task automatic hold(input int half);
      repeat (half) @(posedge core_clk);
      #7;
   endtask

   // Plain pulses; channel one uses the phase B pin
   task automatic train(input int ch, input int n, input int half);
      for (int i = 0; i < n; i++) begin
         if (ch == 0) phaseBIn = 1'b1;
         else pulseIn[ch] = 1'b1;
         hold(half);
         if (ch == 0) phaseBIn = 1'b0;
         else pulseIn[ch] = 1'b0;
         hold(half);
      end
   endtask

   // Quadrature: A leads B going up, trails B going down
   task automatic quad(input int n, input logic up, input int half);
      for (int i = 0; i < n; i++) begin
         if (up) phaseAIn = 1'b1;
         else phaseBIn = 1'b1;
         hold(half);
         phaseAIn = 1'b1;
         phaseBIn = 1'b1;
         hold(half);
         if (up) phaseAIn = 1'b0;
         else phaseBIn = 1'b0;
         hold(half);
         phaseAIn = 1'b0;
         phaseBIn = 1'b0;
         hold(half);
      end
   endtask
endmodule

// file: tb/high_speed_counter_freq_meter_bench.sv
/*
 Self-checking bench for the pulse counter top with a pulse source.
 Assumes a 100-cycle frequency window; inputs move after clock edges.
*/
`timescale 1ns/100ps
`include "hsc_defs.svh"
module high_speed_counter_freq_meter_bench;
   localparam int WIN = 100;
   logic core_clk, resetn, scanEnd, progLoad, regWr, regRd, irq, phaseAIn, phaseBIn;
   logic [3:1] pulseIn;
   logic [`HSC_AW-1:0] regAddr;
   logic [`HSC_DW-1:0] regWrData, regRdData, rdv;
   logic [`HSC_NCH-1:0] compareOut;
   logic [7:0] zeroRegs [6];
   hsc_pkg::hsc_val_t n, r, v;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;

   hsc_top #(.WIN_CYC(WIN)) dut (.core_clk(core_clk), .resetn(resetn), .scanEnd(scanEnd), .progLoad(progLoad),
      .phaseAIn(phaseAIn), .phaseBIn(phaseBIn), .pulseCh2In(pulseIn[1]), .pulseCh3In(pulseIn[2]),
      .pulseCh4In(pulseIn[3]), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .compareOut(compareOut), .irq(irq));
   hsc_pulse_src src (.core_clk(core_clk), .phaseAIn(phaseAIn), .phaseBIn(phaseBIn), .pulseIn(pulseIn));

   function automatic logic [7:0] chReg(input int ch, input logic [2:0] f);
      return 8'h20 + 8'(ch * 8) + {5'h00, f};
   endfunction
   function automatic hsc_pkg::hsc_val_t freqOf(input int pulses);
      return 32'(pulses * `HSC_HZ_SCALE);
   endfunction
   task automatic chk(input string what, input hsc_pkg::hsc_val_t exp, input hsc_pkg::hsc_val_t got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Frequency tolerates one pulse of window phase
   task automatic chkFreq(input int pulses);
      comparisons++;
      if (v < freqOf(pulses - 1) || v > freqOf(pulses + 1)) begin
         num_errors++;
         $display("CHECK FAILED frequency expected %0d seen %0d", freqOf(pulses), v);
      end
   endtask
   // Waits end just past the edge so registered outputs have settled
   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 rdv = regRdData;
   endtask
   // No atomicity: high word first, then low word
   task automatic rd32(input logic [7:0] a);
      rd(a);
      v[31:16] = rdv;
      rd(a + 8'h01);
      v[15:0] = rdv;
   endtask
   task automatic wr32(input logic [7:0] a, input hsc_pkg::hsc_val_t d);
      wr(a, d[31:16]);
      wr(a + 8'h01, d[15:0]);
   endtask
   task automatic strobe(input logic isLoad);
      @(posedge core_clk);
      if (isLoad) progLoad <= 1'b1;
      else scanEnd <= 1'b1;
      @(posedge core_clk);
      progLoad <= 1'b0;
      scanEnd <= 1'b0;
   endtask
   task automatic end_of_test();
      $display("Mismatches %0d in %0d comparisons", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // Hang guard: the planned run needs well under 3000 clocks
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         $display("CHECK FAILED run length expected finish seen hang");
         end_of_test();
      end
   end

   initial begin
      {resetn, scanEnd, progLoad, regWr, regRd} = 5'h00;
      regAddr = 8'h00;
      regWrData = 16'h0000;
      void'($urandom(32'h9c834486));
      zeroRegs = '{`HSC_REG_CTRL, `HSC_REG_MODE, `HSC_REG_IRQ_EN, 8'h10, chReg(1, `HSC_F_PRE_LO), `HSC_REG_STAT};
      repeat (16) @(posedge core_clk);
      resetn <= 1'b1;
      // Reset values, unmapped place, and a write to a read-only word
      wr(`HSC_REG_STAT, 16'hffff);
      foreach (zeroRegs[i]) begin
         rd(zeroRegs[i]);
         chk("reset value", 0, rdv);
      end
      // Single-phase channel two: gate, reset flag, match, clear
      n = 3 + $urandom % 6;
      wr(`HSC_REG_IRQ_EN, 16'h0002);
      wr32(chReg(1, `HSC_F_PRE_HI), n);
      rd32(chReg(1, `HSC_F_PRE_HI));
      chk("preset one", n, v);
      src.train(1, 2, 3);
      wr(`HSC_REG_CTRL, 16'h0002);
      src.train(1, 1, 3);
      cyc(10);
      rd32(chReg(1, `HSC_F_CUR_HI));
      chk("count before scan end", 0, v);
      strobe(1'b0);
      src.train(1, 2, 3);
      cyc(10);
      rd32(chReg(1, `HSC_F_CUR_HI));
      chk("count after scan end", 2, v);
      wr(`HSC_REG_CTRL, 16'h0022);
      strobe(1'b0);
      wr(`HSC_REG_CTRL, 16'h0002);
      rd32(chReg(1, `HSC_F_CUR_HI));
      chk("count after reset flag", 0, v);
      src.train(1, n, 3);
      cyc(10);
      chk("compare on match", 4'h2, compareOut);
      chk("irq on match", 1, irq);
      rd32(chReg(1, `HSC_F_CUR_HI));
      chk("restart from zero", 0, v);
      wr(`HSC_REG_IRQ_CLR, 16'h0002);
      cyc(1);
      chk("irq cleared", 0, irq);
      chk("compare held", 4'h2, compareOut);
      wr(`HSC_REG_CTRL, 16'h0202);
      cyc(2);
      chk("compare cleared", 4'h0, compareOut);
      wr(`HSC_REG_CTRL, 16'h0002);
      wr32(chReg(1, `HSC_F_PRE_HI), n + 2);
      src.train(1, n, 3);
      cyc(10);
      chk("old preset still active", 4'h2, compareOut);
      wr(`HSC_REG_CTRL, 16'h0202);
      wr(`HSC_REG_CTRL, 16'h0002);
      src.train(1, n + 1, 3);
      cyc(10);
      chk("new preset not reached", 4'h0, compareOut);
      src.train(1, 1, 3);
      cyc(10);
      chk("new preset reached", 4'h2, compareOut);
      // Two-phase channel one: reload, match without keep, direction
      r = 32'h100 + $urandom % 32'h7000;
      wr32(chReg(0, `HSC_F_RLD_HI), r);
      wr32(chReg(0, `HSC_F_PRE_HI), r + 3);
      wr(`HSC_REG_CTRL, 16'h2011);
      strobe(1'b0);
      wr(`HSC_REG_CTRL, 16'h2001);
      rd32(chReg(0, `HSC_F_CUR_HI));
      chk("reload on reset", r, v);
      src.quad(3, 1'b1, 3);
      cyc(10);
      chk("two-phase compare", 1, compareOut[0]);
      rd32(chReg(0, `HSC_F_CUR_HI));
      chk("new cycle from reload", r, v);
      src.quad(1, 1'b1, 3);
      src.quad(4, 1'b0, 3);
      cyc(10);
      rd32(chReg(0, `HSC_F_CUR_HI));
      chk("up then down", r - 3, v);
      wr(`HSC_REG_CTRL, 16'h3001);
      src.quad(6, 1'b1, 3);
      rd32(chReg(0, `HSC_F_CUR_HI));
      chk("kept at preset", r + 3, v);
      // Frequency on channel three, channel four stays empty
      wr(`HSC_REG_MODE, 16'h0004);
      wr(`HSC_REG_CTRL, 16'h0004);
      fork
         src.train(2, 40, 5);
      join_none
      cyc(20);
      strobe(1'b0);
      cyc(150);
      strobe(1'b0);
      rd32(chReg(2, `HSC_F_FRQ_HI));
      chkFreq(WIN / 10);
      rd32(chReg(2, `HSC_F_CUR_HI));
      chk("no counting in frequency mode", 0, v);
      rd32(chReg(3, `HSC_F_FRQ_HI));
      chk("other result untouched", 0, v);
      wr(`HSC_REG_IRQ_CLR, 16'h00f0);
      cyc(110);
      wr(`HSC_REG_REFRESH, 16'h0004);
      rd(`HSC_REG_IRQ_STAT);
      chk("refresh publishes", 1, rdv[6]);
      rd32(chReg(2, `HSC_F_FRQ_HI));
      chkFreq(WIN / 10);
      cyc(100);
      // Load with gate high halts until the gate is cycled
      wr(`HSC_REG_MODE, 16'h0000);
      wr(`HSC_REG_CTRL, 16'h0002);
      strobe(1'b1);
      strobe(1'b0);
      rd(`HSC_REG_STAT);
      chk("halted after load", 2'b10, {rdv[9], rdv[5]});
      wr(`HSC_REG_CTRL, 16'h0000);
      strobe(1'b0);
      wr(`HSC_REG_CTRL, 16'h0002);
      strobe(1'b0);
      rd(`HSC_REG_STAT);
      chk("running after gate cycle", 2'b01, {rdv[9], rdv[5]});
      end_of_test();
   end
endmodule
